// File: src/asm_pkg.sv
// Shared constants and types for the AES sample multiplexer.
// Assumes a 40 MHz system clock and 16 AES channels of 24-bit audio.
package asm_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int LANES = 16;
  localparam int SAMPLE_W = 24;
  localparam int BUS_W = LANES * SAMPLE_W;
  // Pass-through delay in sample periods per speed
  localparam int DELAY_SINGLE = 3;
  localparam int DELAY_DOUBLE = 6;
  localparam int DELAY_QUAD = 12;
  localparam int DL_DEPTH = DELAY_QUAD;
  // Reference lock range in Hz, and its period limits in clock cycles
  localparam int LOCK_MIN_HZ = 28_000;
  localparam int LOCK_MAX_HZ = 200_000;
  localparam int DEF_HZ = 48_000;
  localparam int PER_W = 11;
  localparam logic [PER_W-1:0] PER_MIN = PER_W'((CLK_HZ + LOCK_MAX_HZ - 1) / LOCK_MAX_HZ);
  localparam logic [PER_W-1:0] PER_MAX = PER_W'(CLK_HZ / LOCK_MIN_HZ);
  localparam logic [PER_W-1:0] PER_DEF = PER_W'(CLK_HZ / DEF_HZ);
  // Mode pin positions in the synchronised mode word
  localparam int CFG_DOUBLE = 0;
  localparam int CFG_QUAD = 1;
  localparam int CFG_F96 = 2;
  localparam int CFG_F192 = 3;
  localparam int CFG_W = 4;
  // Speed codes equal the rate multiplier
  typedef enum logic [2:0] {
    SPD_SINGLE = 3'h1,
    SPD_DOUBLE = 3'h2,
    SPD_QUAD = 3'h4
  } asm_speed_t;
  typedef enum logic [2:0] {
    FRM_48K = 3'h1,
    FRM_96K = 3'h2,
    FRM_192K = 3'h4
  } asm_frame_t;
endpackage

// File: src/asm_clk_if.sv
// Carrier between the clock recovery unit and the sample path.
// Assumes both ends sit on the 40 MHz system clock.
`timescale 1ns/1ps
`default_nettype none
interface asm_clk_if;
  logic sample_tick;
  logic wclk;
  logic locked;
  logic [2:0] rate_mult;
  modport gen (output sample_tick, output wclk, output locked, input rate_mult);
  modport use_side (input sample_tick, input wclk, input locked, output rate_mult);
endinterface
`default_nettype wire

// File: src/asm_clk_rec.sv
// Reference clock recovery: measures the word reference period, smooths it,
// and makes the word clock and the internal sample tick.
// Assumes the reference pin is asynchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module asm_clk_rec (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Reference pin
  input wire logic ref_clk_in,
  // Toward the sample path
  asm_clk_if.gen ck
);
  logic [2:0] ref_sync_q;
  logic [asm_pkg::PER_W-1:0] cnt_q, avg_q, wc_q;
  logic [12:0] acc_q;
  logic [12:0] acc_sum;
  logic [12:0] avg_mix;
  logic ref_edge, in_range;

  assign ref_edge = ref_sync_q[1] & ~ref_sync_q[2];
  assign in_range = (cnt_q >= asm_pkg::PER_MIN) && (cnt_q <= asm_pkg::PER_MAX);
  assign acc_sum = acc_q + 13'(ck.rate_mult);
  // Smoothing keeps three quarters of the old period to reject jitter
  assign avg_mix = 13'(({2'h0, avg_q} * 13'h3 + {2'h0, cnt_q}) >> 2);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ref_sync_q <= 3'h0;
      cnt_q <= '0;
    end else begin
      ref_sync_q <= {ref_sync_q[1:0], ref_clk_in};
      if (ref_edge) cnt_q <= 11'h1;
      else if (cnt_q <= asm_pkg::PER_MAX) cnt_q <= cnt_q + 11'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ck.locked <= 1'b0;
      avg_q <= asm_pkg::PER_DEF;
    end else if (ref_edge && in_range) begin
      ck.locked <= 1'b1;
      avg_q <= ck.locked ? avg_mix[10:0] : cnt_q;
    end else if (ref_edge || cnt_q > asm_pkg::PER_MAX) begin
      // Lost reference falls back to the internal rate
      ck.locked <= 1'b0;
      avg_q <= asm_pkg::PER_DEF;
    end
  end

  // Exactly rate_mult ticks per smoothed reference period
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= '0;
      ck.sample_tick <= 1'b0;
    end else if (acc_sum >= {2'h0, avg_q}) begin
      acc_q <= (acc_sum - {2'h0, avg_q} >= {2'h0, avg_q}) ? 13'h0 : acc_sum - {2'h0, avg_q};
      ck.sample_tick <= 1'b1;
    end else begin
      acc_q <= acc_sum;
      ck.sample_tick <= 1'b0;
    end
  end

  // Word clock runs in every mode, locked or not
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wc_q <= '0;
      ck.wclk <= 1'b0;
    end else begin
      wc_q <= (wc_q >= avg_q - 11'h1) ? 11'h0 : wc_q + 11'h1;
      ck.wclk <= (wc_q < (avg_q >> 1));
    end
  end

  logic [11:0] still_q;
  logic wclk_prev_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      still_q <= '0;
      wclk_prev_q <= 1'b0;
    end else begin
      wclk_prev_q <= ck.wclk;
      if (ck.wclk != wclk_prev_q) still_q <= '0;
      else if (still_q != 12'hFFF) still_q <= still_q + 12'h1;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_wclk_runs: assert property (still_q < 12'h600)
    else $error("word clock stopped");
  a_lock_range: assert property ($rose(ck.locked) |-> $past(in_range) && $past(ref_edge))
    else $error("locked outside the reference range");
  a_tick_rate: assert property (ck.sample_tick |=> !ck.sample_tick || ck.rate_mult != 3'h1)
    else $error("single rate tick came too fast");
  c_locked: cover property ($rose(ck.locked));
endmodule
`default_nettype wire

// File: src/asm_top.sv
// Sample multiplexer top: sample-multiplexed demux on receive, fixed
// pass-through delay, and remux onto 16 AES lanes on transmit.
// Assumes rx_data is valid on the system clock at each transmit frame pulse.
`timescale 1ns/1ps
`default_nettype none
module asm_top (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Reference and mode pins
  input wire logic ref_clk_in,
  input wire logic double_rate_mode,
  input wire logic quadruple_rate_mode,
  input wire logic frame_96k,
  input wire logic frame_192k,
  // AES receive lanes
  input wire logic [asm_pkg::BUS_W-1:0] rx_data,
  // AES transmit lanes and clocks
  output logic [asm_pkg::BUS_W-1:0] tx_data,
  output logic tx_frame,
  output logic word_clk_out,
  output logic ref_locked,
  output logic sample_multiplexing
);
  localparam int W = asm_pkg::SAMPLE_W;

  logic rst_s1_q, rst_n;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  asm_clk_if ck ();
  asm_clk_rec u_clk_rec (
    .clock(clock),
    .rst_n(rst_n),
    .ref_clk_in(ref_clk_in),
    .ck(ck)
  );

  // Mode pins are static straps, synchronised and taken once two samples in a row agree, at any point in a frame
  logic [asm_pkg::CFG_W-1:0] cfg1_q, cfg2_q, cfg3_q, cfg_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg1_q <= '0;
      cfg2_q <= '0;
      cfg3_q <= '0;
      cfg_q <= '0;
    end else begin
      cfg1_q <= {frame_192k, frame_96k, quadruple_rate_mode, double_rate_mode};
      cfg2_q <= cfg1_q;
      cfg3_q <= cfg2_q;
      if (cfg2_q == cfg3_q) cfg_q <= cfg3_q;
    end
  end

  asm_pkg::asm_speed_t speed;
  asm_pkg::asm_frame_t frame;
  logic [2:0] grp;
  logic g1, g2, g4;
  assign speed = cfg_q[asm_pkg::CFG_QUAD] ? asm_pkg::SPD_QUAD :
                 cfg_q[asm_pkg::CFG_DOUBLE] ? asm_pkg::SPD_DOUBLE : asm_pkg::SPD_SINGLE;
  assign frame = (cfg_q[asm_pkg::CFG_F192] && speed == asm_pkg::SPD_QUAD) ? asm_pkg::FRM_192K :
                 (cfg_q[asm_pkg::CFG_F96] || cfg_q[asm_pkg::CFG_F192]) ? asm_pkg::FRM_96K :
                 asm_pkg::FRM_48K;
  assign ck.rate_mult = 3'(speed);
  // Lanes per audio channel: rate multiple over frame multiple
  assign grp = (speed == asm_pkg::SPD_QUAD && frame == asm_pkg::FRM_48K) ? 3'h4 :
               (speed == asm_pkg::SPD_QUAD && frame == asm_pkg::FRM_96K) ? 3'h2 :
               (speed == asm_pkg::SPD_DOUBLE && frame == asm_pkg::FRM_48K) ? 3'h2 :
               3'h1;
  assign g1 = (grp == 3'h1);
  assign g2 = (grp == 3'h2);
  assign g4 = (grp == 3'h4);

  logic tick, last;
  logic [1:0] ph_q;
  logic [3:0] tap_idx;
  assign tick = ck.sample_tick;
  assign last = (ph_q == 2'(grp - 3'h1));
  assign tap_idx = (speed == asm_pkg::SPD_QUAD) ? 4'(asm_pkg::DELAY_QUAD - 1) :
                   (speed == asm_pkg::SPD_DOUBLE) ? 4'(asm_pkg::DELAY_DOUBLE - 1) :
                   4'(asm_pkg::DELAY_SINGLE - 1);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) ph_q <= 2'h0;
    else if (tick) ph_q <= last ? 2'h0 : ph_q + 2'h1;
  end

  // A whole AES frame is latched at once so all group members line up
  logic [asm_pkg::BUS_W-1:0] rx_hold_q, rx_src, samp, build_q, build_nx, dl_tap;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) rx_hold_q <= '0;
    else if (tick && ph_q == 2'h0) rx_hold_q <= rx_data;
  end
  assign rx_src = (ph_q == 2'h0) ? rx_data : rx_hold_q;

  logic [asm_pkg::BUS_W-1:0] dl_q [asm_pkg::DL_DEPTH];
  assign dl_tap = dl_q[tap_idx];

  genvar i;
  generate
    for (i = 0; i < asm_pkg::LANES; i++) begin : g_lane
      logic [W-1:0] s2, s4, src_out;
      logic hit;
      if (i < asm_pkg::LANES / 2) begin : g_d2
        assign s2 = rx_src[(2 * i + ph_q[0]) * W +: W];
      end else begin : g_n2
        assign s2 = '0;
      end
      if (i < asm_pkg::LANES / 4) begin : g_d4
        assign s4 = rx_src[(4 * i + ph_q) * W +: W];
      end else begin : g_n4
        assign s4 = '0;
      end
      // Full 24-bit words in every mode
      assign samp[i * W +: W] = g4 ? s4 : g2 ? s2 : rx_src[i * W +: W];
      assign src_out = g4 ? dl_tap[(i / 4) * W +: W] :
                       g2 ? dl_tap[(i / 2) * W +: W] : dl_tap[i * W +: W];
      assign hit = tick && (g1 || (g2 && ph_q[0] == 1'(i % 2)) ||
                   (g4 && ph_q == 2'(i % 4)));
      assign build_nx[i * W +: W] = hit ? src_out : build_q[i * W +: W];
    end
    for (i = 0; i < asm_pkg::DL_DEPTH; i++) begin : g_dl
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) dl_q[i] <= '0;
        else if (tick) dl_q[i] <= (i == 0) ? samp : dl_q[(i == 0) ? 0 : i - 1];
      end
    end
  endgenerate

  logic [asm_pkg::BUS_W-1:0] tx_q;
  logic tx_frame_q, mux_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      build_q <= '0;
      tx_q <= '0;
      tx_frame_q <= 1'b0;
      mux_q <= 1'b0;
    end else begin
      build_q <= build_nx;
      if (tick && last) tx_q <= build_nx;
      tx_frame_q <= tick && last;
      mux_q <= !g1;
    end
  end

  assign tx_data = tx_q;
  assign tx_frame = tx_frame_q;
  assign word_clk_out = ck.wclk;
  assign ref_locked = ck.locked;
  assign sample_multiplexing = mux_q;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_single_delay: assert property (speed == asm_pkg::SPD_SINGLE |-> tap_idx == 4'h2)
    else $error("single speed delay is not three samples");
  a_double_delay: assert property (speed == asm_pkg::SPD_DOUBLE |-> tap_idx == 4'h5)
    else $error("double speed delay is not six samples");
  // Group size follows the speed and frame straps
  a_group_double: assert property (speed == asm_pkg::SPD_DOUBLE && !cfg_q[2] && !cfg_q[3]
    |-> grp == 3'h2)
    else $error("48K double speed not on two lanes");
  a_group_quad: assert property (speed == asm_pkg::SPD_QUAD && !cfg_q[2] && !cfg_q[3]
    |-> grp == 3'h4)
    else $error("48K quad speed not on four lanes");
  a_native_96: assert property (speed == asm_pkg::SPD_DOUBLE && cfg_q[2] |-> g1)
    else $error("native 96K frame was multiplexed");
  a_quad_96: assert property (speed == asm_pkg::SPD_QUAD && cfg_q[2] && !cfg_q[3] |-> g2)
    else $error("96K frame at quad speed not double wire");
  // The native frame needs no multiplexing at quad speed
  a_native_192: assert property (speed == asm_pkg::SPD_QUAD && cfg_q[3] |-> g1)
    else $error("native 192K frame was multiplexed");
  a_member_place: assert property (tick && g2 && ph_q == 2'h1 |=>
    build_q[W +: W] == $past(dl_tap[W-1:0]))
    else $error("odd sample not in second group member");
  // Lane 3 is the last member of a four-lane group
  a_quad_member: assert property (tick && g4 && ph_q == 2'h3 |=>
    build_q[3 * W +: W] == $past(dl_tap[W-1:0]))
    else $error("fourth sample not in fourth group member");
  a_rx_align: assert property (tick && ph_q == 2'h0 |=> rx_hold_q == $past(rx_data))
    else $error("receive frame not latched whole");
  // Later members read the held frame, so it must not move inside a group
  a_hold_still: assert property (!(tick && ph_q == 2'h0) |=> $stable(rx_hold_q))
    else $error("held receive frame moved inside a group");
  a_full_width: assert property (tick && last && g1 && !g2 |=>
    tx_data == $past(build_nx))
    else $error("transmit word not passed whole");
  a_frame_tick: assert property (tx_frame |-> $past(tick) && $past(last))
    else $error("transmit frame not on a cleaned tick");
  // Downstream sees a whole frame, so words change only on a group boundary
  a_tx_steady: assert property (!(tick && last) |=> $stable(tx_data))
    else $error("transmit data moved between frames");

  c_quad_frame: cover property (g4 && tx_frame);
  c_double_frame: cover property (g2 && tx_frame);
  c_native_frame: cover property (g1 && speed == asm_pkg::SPD_DOUBLE && tx_frame);
  c_single_frame: cover property (speed == asm_pkg::SPD_SINGLE && tx_frame);
endmodule
`default_nettype wire

// File: bench/asm_ref_src.sv
// Far-side word clock source that feeds the reference pin.
// Assumes the bench sets the half period in ns; the line idles low when off.
`timescale 1ns/1ps
`default_nettype none
module asm_ref_src (
  // Control
  input wire logic en,
  input var int half_ns,
  // Reference line
  output logic ref_o
);
  // Stands still between runs so that the lost-reference timeout can be seen
  initial begin
    ref_o = 1'b0;
    forever begin
      if (en) begin
        #(half_ns) ref_o = ~ref_o;
      end else begin
        ref_o = 1'b0;
        #100;
      end
    end
  end
endmodule
`default_nettype wire

// File: bench/aes_sample_multiplexer_tb.sv
// Self-checking bench for the sample multiplexer top.
// Assumes the partner model supplies the word reference on the reference pin.
`timescale 1ns/1ps
`default_nettype none
module aes_sample_multiplexer_tb;
  localparam int W = asm_pkg::BUS_W;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic ref_en = 1'b0;
  int half_ns = 100;
  logic ref_w;
  logic dbl = 1'b0;
  logic quad = 1'b0;
  logic f96 = 1'b0;
  logic f192 = 1'b0;
  logic [W-1:0] rx = '0;
  logic [W-1:0] tx;
  logic [W-1:0] v;
  logic frm;
  logic wclk;
  logic lck;
  logic mux;
  logic streaming = 1'b0;
  logic fresh = 1'b1;
  logic [W-1:0] q[$];
  int miscompares = 0;
  int samples_checked = 0;
  int cyc = 0;
  int lag = 4;
  int last = 0;
  int gap = 833;
  int t0 = 0;
  int seed = 32'h5f09;

  always #12.5 clock = ~clock;

  asm_ref_src ref_u (.en(ref_en), .half_ns(half_ns), .ref_o(ref_w));

  asm_top dut_u (.clock(clock), .rstn(rstn), .ref_clk_in(ref_w), .double_rate_mode(dbl),
    .quadruple_rate_mode(quad), .frame_96k(f96), .frame_192k(f192), .rx_data(rx),
    .tx_data(tx), .tx_frame(frm), .word_clk_out(wclk), .ref_locked(lck),
    .sample_multiplexing(mux));

  task automatic check(input string nm, input logic [W-1:0] e, input logic [W-1:0] s);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic print_verdict();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  function automatic logic [W-1:0] rnd();
    logic [W-1:0] r;
    r = '0;
    for (int i = 0; i < W / 32; i++) begin
      r = {r[W-33:0], 32'($random(seed))};
    end
    return r;
  endfunction

  // Result watcher: oldest note against each new frame, plus frame spacing
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc > 95000) begin
      miscompares++;
      print_verdict();
    end else if (frm && streaming) begin
      if (last != 0) check("frame_gap", W'(1), W'((cyc - last - gap) inside {[-3:3]}));
      last = cyc;
      if (q.size() == lag) check("tx_data", q.pop_front(), tx);
    end
  end

  // Driver: lane data just after each frame pulse, new only while fresh is set, noted for the watcher
  always @(negedge clock) begin
    if (frm && streaming) begin
      v = fresh ? rnd() : rx;
      rx <= v;
      q.push_back(v);
    end
  end

  // Mode switch away from any frame pulse, three frames to settle, then stream.
  // Lag is the delay in frames plus two: one note is taken at the next frame
  // start, one more is queued before the matching frame is checked.
  task automatic run_mode(input logic [3:0] m, input logic xm, input int l, input int g,
                          input logic fr);
    @(posedge clock);
    @(negedge clock);
    streaming = 1'b0;
    q.delete();
    {f192, f96, quad, dbl} = m;
    rx = rnd();
    repeat (3) @(posedge frm);
    @(posedge clock);
    @(negedge clock);
    check("mux", W'(xm), W'(mux));
    lag = l;
    gap = g;
    fresh = fr;
    last = 0;
    streaming = 1'b1;
    repeat (l + 6) @(posedge frm);
  endtask

  initial begin
    repeat (8) @(posedge clock);
    @(negedge clock);
    rstn = 1'b1;
    // 200 ns link clock is far above the lock range
    ref_en = 1'b1;
    repeat (3000) @(posedge clock);
    check("locked", W'(0), W'(lck));
    half_ns = 10413;
    repeat (4000) @(posedge clock);
    check("locked", W'(1), W'(lck));
    @(posedge wclk);
    t0 = cyc;
    @(posedge wclk);
    check("wclk_gap", W'(1), W'((cyc - t0) inside {[830:836]}));
    run_mode(4'h0, 1'b0, 5, 833, 1'b1);
    run_mode(4'h5, 1'b0, 8, 416, 1'b1);
    run_mode(4'hA, 1'b0, 14, 208, 1'b1);
    run_mode(4'h1, 1'b1, 5, 833, 1'b1);
    run_mode(4'h2, 1'b1, 5, 833, 1'b1);
    run_mode(4'h6, 1'b1, 8, 416, 1'b0);
    streaming = 1'b0;
    ref_en = 1'b0;
    repeat (1600) @(posedge clock);
    check("locked", W'(0), W'(lck));
    print_verdict();
  end
endmodule
`default_nettype wire
